// File: ext_mem_pkg.sv
package ext_mem_pkg;

    // ==========================================================
    // Register map, byte addresses on the 32-bit register port
    // ==========================================================
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] ADDR_OFFSET     = 8'h04;
    localparam logic [7:0] WDATA_OFFSET    = 8'h08;
    localparam logic [7:0] RDATA_OFFSET    = 8'h0C;
    localparam logic [7:0] STATUS_OFFSET   = 8'h10;
    localparam logic [7:0] PARAM_OFFSET    = 8'h20;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_WRITE_BIT   = 1;
    localparam int CTRL_BE_LSB      = 4;
    localparam int CTRL_REGION_LSB  = 8;
    localparam int STATUS_BUSY_BIT  = 0;
    localparam int STATUS_DONE_BIT  = 1;

    // ==========================================================
    // Reset values and sizes
    // ==========================================================
    localparam logic [15:0] PARAM_RESET   = 16'h0000;
    localparam logic [15:0] ADDR_RESET    = 16'h0000;
    localparam logic [15:0] WDATA_RESET   = 16'h0000;
    localparam logic [1:0]  BE_RESET      = 2'h3;
    localparam int          CNT_W         = 6;
    localparam int          SYNC_STAGES   = 2;
    // One interface clock period is two core cycles; one core cycle is a half period.
    localparam int          HALF_PER_CLK  = 2;

    // Timing parameter of one region.
    typedef struct packed {
        logic       spare_hi;
        logic [2:0] ale_len;
        logic       spare_mid;
        logic       addr_hold_skip;  // bit 10
        logic       rd_hold_skip;    // bit 9
        logic       wr_hold_skip;    // bit 8
        logic [3:0] wr_len;
        logic [3:0] rd_len;
    } ext_region_timing_param_type;

    // Pins toward the memory; all from flip-flops.
    typedef struct packed {
        logic        memory_select_n;
        logic        address_latch_enable;
        logic        write_strobe_n;
        logic        read_strobe_n;
        logic [1:0]  byte_lane_enable_n;
        logic        addr_valid;
        logic        ad_oe;
        logic [15:0] ad_out;
    } pin_out_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SELECT = 3'b001,
        ST_LATCH  = 3'b010,
        ST_GAP    = 3'b011,
        ST_STROBE = 3'b100,
        ST_TAIL   = 3'b101
    } cycle_state_type;

    // Phase lengths in half periods.
    function automatic logic [5:0] ale_half(input ext_region_timing_param_type p);
        return 6'({p.ale_len, 1'b0}) + 6'h02;
    endfunction

    function automatic logic [5:0] addr_hold_half(input ext_region_timing_param_type p);
        return p.addr_hold_skip ? 6'h01 : 6'h03;
    endfunction

    function automatic logic [5:0] strobe_delay_half(input ext_region_timing_param_type p,
                                                     input logic is_write);
        logic extra;
        extra = is_write ? p.wr_hold_skip : p.rd_hold_skip;
        return 6'h01 + (p.addr_hold_skip ? 6'h00 : 6'h02) + (extra ? 6'h00 : 6'h02);
    endfunction

    function automatic logic [5:0] strobe_half(input ext_region_timing_param_type p,
                                               input logic is_write);
        logic [3:0] n;
        n = is_write ? p.wr_len : p.rd_len;
        return 6'({n, 1'b0}) + 6'h02;
    endfunction

    function automatic logic [5:0] tail_half(input ext_region_timing_param_type p,
                                             input logic is_write);
        return (is_write && !p.wr_hold_skip) ? 6'h04 : 6'h02;
    endfunction

endpackage

// File: ext_mem_half_tick_counter.sv
module ext_mem_half_tick_counter
    import ext_mem_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    input  wire logic             core_clk,  // Core clock, one half period per cycle
    input  wire logic             rstn,      // Asynchronous reset, active low
    input  wire logic             restart,   // Restart from zero in the next cycle
    output logic [WIDTH-1:0]      count      // Half periods spent in the phase
);

    initial begin
        if (WIDTH < 6) begin
            $error("counter too narrow for the longest phase");
        end
    end

    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = restart ? '0 : count + WIDTH'(1);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// File: ext_mem_bus_cycle_timing.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module ext_mem_bus_cycle_timing
    import ext_mem_pkg::*;
#(
    parameter int REGIONS = 4
) (
    input  wire logic              core_clk,    // Core clock, 20 MHz
    input  wire logic              rstn,        // Asynchronous reset, active low
    input  wire logic [ADDR_W-1:0] reg_addr,    // Register byte address
    input  wire logic [31:0]       reg_wdata,   // Register write data
    input  wire logic              reg_write,   // Register write strobe
    input  wire logic              reg_read,    // Register read strobe
    output logic [31:0]            reg_rdata,   // Read data, cycle after the read strobe
    output logic                   mem_clk,     // Interface clock, core clock over two
    output pin_out_type            mem_pins,    // Strobes and address/data toward memory
    input  wire logic [15:0]       mem_ad_in    // Address/data pins as read back
);

    initial begin
        if (REGIONS < 1 || REGIONS > 4) begin
            $error("REGIONS must be 1 to 4");
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    ext_region_timing_param_type ext_region_timing_param [REGIONS];
    logic [15:0] addr_reg, wdata_reg, rdata_reg;
    logic [1:0]  be_reg, region_reg;
    logic        write_mode, start_pending, done_flag;

    ext_region_timing_param_type next_param [REGIONS];
    logic [15:0] next_addr_reg, next_wdata_reg, next_rdata_reg;
    logic [1:0]  next_be_reg, next_region_reg;
    logic        next_write_mode, next_start_pending, next_done_flag;
    logic [31:0] next_reg_rdata;

    cycle_state_type state, next_state;
    pin_out_type     next_pins;
    ext_region_timing_param_type cur;
    logic [CNT_W-1:0] count;
    logic             restart, cycle_end, busy;
    logic [15:0]      ad_sync1, ad_sync2;

    assign busy      = (state != ST_IDLE) || !mem_pins.memory_select_n;
    assign cycle_end = (state == ST_IDLE) && !mem_pins.memory_select_n;

    always_comb begin
        next_param         = ext_region_timing_param;
        next_addr_reg      = addr_reg;
        next_wdata_reg     = wdata_reg;
        next_be_reg        = be_reg;
        next_region_reg    = region_reg;
        next_write_mode    = write_mode;
        next_start_pending = start_pending;
        next_done_flag     = done_flag;
        next_rdata_reg     = rdata_reg;
        next_reg_rdata     = 32'h0000_0000;
        if (reg_write) begin
            if (reg_addr == CTRL_OFFSET && !busy && !start_pending) begin
                next_write_mode    = reg_wdata[CTRL_WRITE_BIT];
                next_be_reg        = reg_wdata[CTRL_BE_LSB +: 2];
                next_region_reg    = reg_wdata[CTRL_REGION_LSB +: 2];
                next_start_pending = reg_wdata[CTRL_START_BIT];
            end
            if (reg_addr == ADDR_OFFSET && !busy) begin
                next_addr_reg = reg_wdata[15:0];
            end
            if (reg_addr == WDATA_OFFSET && !busy) begin
                next_wdata_reg = reg_wdata[15:0];
            end
            if (reg_addr == STATUS_OFFSET && reg_wdata[STATUS_DONE_BIT]) begin
                next_done_flag = 1'b0;
            end
            for (int r = 0; r < REGIONS; r++) begin
                if (reg_addr == PARAM_OFFSET + ADDR_W'(4 * r)) begin
                    next_param[r] = reg_wdata[15:0];
                end
            end
        end
        if (state == ST_IDLE && start_pending && mem_clk == 1'b1) begin
            next_start_pending = 1'b0;
        end
        // The synchroniser delays the pins by two cycles, so the value taken when
        // select is released is the one seen in the last strobe-low cycle.
        if (cycle_end) begin
            next_done_flag = 1'b1;
            if (!write_mode) begin
                next_rdata_reg = ad_sync2;
            end
        end
        if (reg_read) begin
            case (reg_addr)
                CTRL_OFFSET:   next_reg_rdata = {22'h0, region_reg, 2'h0, be_reg, 2'h0,
                                                 write_mode, start_pending};
                ADDR_OFFSET:   next_reg_rdata = {16'h0, addr_reg};
                WDATA_OFFSET:  next_reg_rdata = {16'h0, wdata_reg};
                RDATA_OFFSET:  next_reg_rdata = {16'h0, rdata_reg};
                STATUS_OFFSET: next_reg_rdata = {30'h0, done_flag, busy};
                default: begin
                    for (int r = 0; r < REGIONS; r++) begin
                        if (reg_addr == PARAM_OFFSET + ADDR_W'(4 * r)) begin
                            next_reg_rdata = {16'h0, ext_region_timing_param[r]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int r = 0; r < REGIONS; r++) begin
                ext_region_timing_param[r] <= PARAM_RESET;
            end
            addr_reg      <= ADDR_RESET;
            wdata_reg     <= WDATA_RESET;
            rdata_reg     <= 16'h0000;
            be_reg        <= BE_RESET;
            region_reg    <= 2'h0;
            write_mode    <= 1'b0;
            start_pending <= 1'b0;
            done_flag     <= 1'b0;
            reg_rdata     <= 32'h0000_0000;
        end else begin
            ext_region_timing_param <= next_param;
            addr_reg      <= next_addr_reg;
            wdata_reg     <= next_wdata_reg;
            rdata_reg     <= next_rdata_reg;
            be_reg        <= next_be_reg;
            region_reg    <= next_region_reg;
            write_mode    <= next_write_mode;
            start_pending <= next_start_pending;
            done_flag     <= next_done_flag;
            reg_rdata     <= next_reg_rdata;
        end
    end

    // ==========================================================
    // Cycle sequencer, one count per half interface period
    // ==========================================================
    assign cur = ext_region_timing_param[region_reg];

    ext_mem_half_tick_counter #(.WIDTH(CNT_W)) u_half_tick (
        .core_clk (core_clk),
        .rstn     (rstn),
        .restart  (restart),
        .count    (count)
    );

    always_comb begin
        next_state = state;
        restart    = 1'b1;
        case (state)
            // Starting while the interface clock is high puts select on its next rising edge,
            // since the pins lag the state by one core cycle.
            ST_IDLE:   if (start_pending && mem_clk == 1'b1) next_state = ST_SELECT;
            ST_SELECT: next_state = ST_LATCH;
            ST_LATCH: begin
                if (count == ale_half(cur) - 6'h01) next_state = ST_GAP;
                else restart = 1'b0;
            end
            ST_GAP: begin
                if (count == strobe_delay_half(cur, write_mode) - 6'h01) begin
                    next_state = ST_STROBE;
                end else restart = 1'b0;
            end
            ST_STROBE: begin
                if (count == strobe_half(cur, write_mode) - 6'h01) begin
                    next_state = ST_TAIL;
                end else restart = 1'b0;
            end
            ST_TAIL: begin
                if (count == tail_half(cur, write_mode) - 6'h01) next_state = ST_IDLE;
                else restart = 1'b0;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Pins are computed from the state and registered, so every edge lands on a
    // core clock edge, that is on a half period of the interface clock.
    always_comb begin
        next_pins                      = '0;
        next_pins.memory_select_n      = (state == ST_IDLE);
        next_pins.read_strobe_n        = 1'b1;
        next_pins.write_strobe_n       = 1'b1;
        next_pins.byte_lane_enable_n   = 2'h3;
        next_pins.address_latch_enable = (state == ST_LATCH);
        next_pins.addr_valid = (state == ST_SELECT) || (state == ST_LATCH) ||
                               (state == ST_GAP && count < addr_hold_half(cur));
        if (state == ST_STROBE) begin
            next_pins.write_strobe_n = !write_mode;
            next_pins.read_strobe_n  = write_mode;
        end
        if ((state == ST_GAP && count != 6'h00) || state == ST_STROBE || state == ST_TAIL) begin
            next_pins.byte_lane_enable_n = be_reg;
        end
        if (next_pins.addr_valid) begin
            next_pins.ad_oe  = 1'b1;
            next_pins.ad_out = addr_reg;
        end else if (write_mode && state != ST_IDLE) begin
            next_pins.ad_oe  = 1'b1;
            next_pins.ad_out = wdata_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            mem_clk  <= 1'b0;
            mem_pins <= '{memory_select_n: 1'b1, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
                          byte_lane_enable_n: 2'h3, default: '0};
            ad_sync1 <= 16'h0000;
            ad_sync2 <= 16'h0000;
        end else begin
            state    <= next_state;
            mem_clk  <= !mem_clk;
            mem_pins <= next_pins;
            ad_sync1 <= mem_ad_in;
            ad_sync2 <= ad_sync1;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    logic [CNT_W-1:0] ale_run, ale_age, strobe_run, rel_age;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ale_run    <= '0;
            ale_age    <= '0;
            strobe_run <= '0;
            rel_age    <= '0;
        end else begin
            ale_run    <= mem_pins.address_latch_enable ? ale_run + 6'h01 : 6'h00;
            ale_age    <= mem_pins.address_latch_enable ? 6'h00 : ale_age + 6'h01;
            strobe_run <= (mem_pins.write_strobe_n && mem_pins.read_strobe_n) ? 6'h00
                                                                          : strobe_run + 6'h01;
            rel_age    <= (mem_pins.write_strobe_n && mem_pins.read_strobe_n) ? rel_age + 6'h01
                                                                          : 6'h00;
        end
    end

    property p_ale_width;
        @(posedge core_clk) disable iff (!rstn)
        $fell(mem_pins.address_latch_enable) |-> ale_run == ale_half(cur);
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("ALE width wrong");

    property p_addr_hold;
        @(posedge core_clk) disable iff (!rstn)
        $fell(mem_pins.addr_valid) |-> ale_age == addr_hold_half(cur);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address hold wrong");

    property p_wr_delay;
        @(posedge core_clk) disable iff (!rstn)
        $fell(mem_pins.write_strobe_n) |-> ale_age == strobe_delay_half(cur, 1'b1);
    endproperty
    a_wr_delay: assert property (p_wr_delay) else $error("write strobe delay wrong");

    property p_wr_width;
        @(posedge core_clk) disable iff (!rstn)
        $rose(mem_pins.write_strobe_n) |-> strobe_run == strobe_half(cur, 1'b1);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");

    property p_ms_release;
        @(posedge core_clk) disable iff (!rstn)
        $rose(mem_pins.memory_select_n) |-> rel_age == tail_half(cur, write_mode);
    endproperty
    a_ms_release: assert property (p_ms_release) else $error("select release wrong");

    property p_rd_width;
        @(posedge core_clk) disable iff (!rstn)
        $rose(mem_pins.read_strobe_n) |-> strobe_run == strobe_half(cur, 1'b0);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");

    property p_rd_delay;
        @(posedge core_clk) disable iff (!rstn)
        $fell(mem_pins.read_strobe_n) |-> ale_age == strobe_delay_half(cur, 1'b0);
    endproperty
    a_rd_delay: assert property (p_rd_delay) else $error("read strobe delay wrong");

    property p_half_align;
        @(posedge core_clk) disable iff (!rstn)
        $fell(mem_pins.memory_select_n) |-> mem_clk ##1 mem_pins.address_latch_enable && !mem_clk;
    endproperty
    a_half_align: assert property (p_half_align) else $error("edges off half period");

endmodule

// File: mem_model.sv
module mem_model
    import ext_mem_pkg::*;
(
    input  wire logic        core_clk,   // Core clock
    input  wire logic        rstn,       // Asynchronous reset, active low
    input  wire pin_out_type pins,       // Strobes and address/data from the device
    input  wire logic        long_hold,  // Hold read data one extra clock
    output logic [15:0]      ad_in       // Address/data pins as driven by the memory
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Storage and cycle tracking
    // ==========================================================
    logic [15:0] mem [int];
    logic [15:0] addr;
    logic [15:0] rd_word;
    logic        prev_ale;
    logic        prev_wr_n;
    logic [2:0]  since_rd;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_ale  <= 1'b0;
            prev_wr_n <= 1'b1;
            since_rd  <= 3'h7;
            rd_word   <= 16'h0000;
            addr      <= 16'h0000;
        end else begin
            prev_ale  <= pins.address_latch_enable;
            prev_wr_n <= pins.write_strobe_n;
            if (prev_ale && !pins.address_latch_enable) begin
                addr    <= pins.ad_out;
                rd_word <= mem.exists(int'(pins.ad_out)) ? mem[int'(pins.ad_out)] : 16'h5A5A;
            end
            if (!prev_wr_n && pins.write_strobe_n) begin
                mem[int'(addr)] = pins.ad_out;
            end
            if (!pins.read_strobe_n) begin
                since_rd <= 3'h0;
            end else if (since_rd != 3'h7) begin
                since_rd <= since_rd + 3'h1;
            end
        end
    end

    // Once the hold runs out the pins show the inverse, so a late sample cannot pass.
    assign ad_in = (!pins.read_strobe_n || since_rd < (long_hold ? 3'h3 : 3'h1)) ? rd_word
                                                                              : ~rd_word;
endmodule

// File: testbench.sv
module testbench
    import ext_mem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0]       reg_wdata = '0;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [31:0]       reg_rdata;
    logic              mem_clk;
    pin_out_type       mem_pins;
    pin_out_type       prev;
    logic [15:0]       mem_ad_in;
    logic              long_hold = 1'b1;
    logic [1:0]        ben_seen;
    logic              clk_at_sel;
    logic              oe_seen;
    integer            err_count = 0;
    integer            n_tests = 0;
    integer            cyc = 0;
    integer            seed = 32'h68020294;
    int                t_ale_r, t_ale_f, t_av_f, t_st_f, t_st_r, t_sel_r;
    int                ref_mem [int];

    ext_mem_bus_cycle_timing #(.REGIONS(4)) DUT (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_clk(mem_clk), .mem_pins(mem_pins), .mem_ad_in(mem_ad_in));

    mem_model partner (.core_clk(core_clk), .rstn(rstn), .pins(mem_pins),
        .long_hold(long_hold), .ad_in(mem_ad_in));

    always #25 core_clk = ~core_clk;

    // ==========================================================
    // Edge timestamps, taken mid-cycle where the pins are settled
    // ==========================================================
    always @(negedge core_clk) begin
        if (mem_pins.address_latch_enable && !prev.address_latch_enable) t_ale_r = cyc;
        if (!mem_pins.address_latch_enable && prev.address_latch_enable) t_ale_f = cyc;
        if (!mem_pins.addr_valid && prev.addr_valid) t_av_f = cyc;
        if (!(mem_pins.write_strobe_n & mem_pins.read_strobe_n)
            && (prev.write_strobe_n & prev.read_strobe_n)) begin
            t_st_f = cyc;
            ben_seen = mem_pins.byte_lane_enable_n;
            oe_seen = mem_pins.ad_oe;
        end
        if ((mem_pins.write_strobe_n & mem_pins.read_strobe_n)
            && !(prev.write_strobe_n & prev.read_strobe_n)) t_st_r = cyc;
        if (mem_pins.memory_select_n && !prev.memory_select_n) t_sel_r = cyc;
        if (!mem_pins.memory_select_n && prev.memory_select_n) clk_at_sel = mem_clk;
        prev = mem_pins;
    end

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // ==========================================================
    // One external cycle with a random region and timing parameter
    // ==========================================================
    task automatic bus_op(input logic wr, input logic [15:0] a);
        logic [15:0] p;
        logic [15:0] d;
        logic [1:0]  r;
        logic [1:0]  be;
        logic [31:0] st;
        int          n;
        r  = 2'($random(seed));
        p  = 16'($random(seed));
        be = 2'($random(seed));
        d  = 16'($random(seed));
        n  = 0;
        long_hold <= !p[9];
        reg_wr(PARAM_OFFSET + {4'h0, r, 2'b00}, {16'h0000, p});
        reg_wr(ADDR_OFFSET, {16'h0000, a});
        if (wr) reg_wr(WDATA_OFFSET, {16'h0000, d});
        reg_wr(CTRL_OFFSET, {22'h0, r, 2'b00, be, 2'b00, wr, 1'b1});
        do begin
            reg_rd(STATUS_OFFSET, st);
            n = n + 1;
        end while (st[STATUS_DONE_BIT] !== 1'b1 && n < 300);
        chk(st, 32'h0000_0002);
        reg_wr(STATUS_OFFSET, 32'h0000_0002);
        chk(t_ale_f - t_ale_r, 2 * (int'(p[14:12]) + 1));
        chk(t_av_f - t_ale_f, 1 + 2 * int'(!p[10]));
        chk(t_st_f - t_ale_f, 1 + 2 * int'(!p[10]) + 2 * int'(wr ? !p[8] : !p[9]));
        chk(t_st_r - t_st_f, 2 * (int'(wr ? p[7:4] : p[3:0]) + 1));
        chk(t_sel_r - t_st_r, wr ? 2 * (int'(!p[8]) + 1) : 2);
        chk({30'h0, ben_seen}, {30'h0, be});
        chk({31'h0, clk_at_sel}, 32'h0000_0001);
        chk({31'h0, oe_seen}, {31'h0, wr});
        if (wr) begin
            ref_mem[int'(a)] = int'(d);
        end else begin
            reg_rd(RDATA_OFFSET, st);
            chk(st, 32'(ref_mem[int'(a)]));
        end
        $display("test done: %s addr=%h param=%h", wr ? "write" : "read", a, p);
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] v;
        logic [15:0] a;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        reg_rd(PARAM_OFFSET + 8'h0C, v);
        chk(v, {16'h0000, PARAM_RESET});
        reg_rd(8'hFC, v);
        chk(v, 32'h0000_0000);
        chk({31'h0, mem_pins.memory_select_n}, 32'h0000_0001);
        $display("test done: reset values");
        for (int i = 0; i < 16; i++) begin
            a = 16'($random(seed));
            bus_op(1'b1, a);
            if (i % 2 == 1) bus_op(1'b1, a);
            bus_op(1'b0, a);
        end
        give_verdict();
    end
endmodule
